// ===== common/sfr_pkg.sv
package sfr_pkg;

  // ------------------------------------------------------------
  // array and command framing
  // ------------------------------------------------------------
  localparam int          ADDR_W           = 23;    // only the implemented address bits
  localparam logic [4:0]  OPC_CLKS_SINGLE  = 5'h08;
  localparam logic [4:0]  OPC_CLKS_QUAD    = 5'h02;
  localparam logic [4:0]  ADDR_CLKS_SINGLE = 5'h18;
  localparam logic [4:0]  ADDR_CLKS_DUAL   = 5'h0C;
  localparam logic [4:0]  ADDR_CLKS_QUAD   = 5'h06;
  localparam logic [3:0]  DUMMY_NONE       = 4'h0;
  localparam logic [3:0]  DUMMY_FAST       = 4'h8;
  localparam logic [3:0]  DUMMY_DUAL_DEF   = 4'h4;  // default for dual_dummy_cycles
  localparam logic [3:0]  DUMMY_QUAD_DEF   = 4'h6;  // default for quad_dummy_cycles
  localparam logic [4:0]  MODE_CLKS_DUAL   = 5'h04;
  localparam logic [3:0]  SKIP_KEY         = 4'hA;

  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0]  OPC_NORMAL_READ  = 8'h03;
  localparam logic [7:0]  OPC_FAST_READ    = 8'h0B;
  localparam logic [7:0]  OPC_TWO_LANE_IO  = 8'hBB;
  localparam logic [7:0]  OPC_FOUR_LANE_IO = 8'hEB;
  localparam logic [7:0]  OPC_UNIQUE_ID    = 8'h4B;
  localparam logic [7:0]  OPC_PARAM_TABLE  = 8'h5A;
  localparam logic [7:0]  OPC_INFO_ROW     = 8'h68;

  // ------------------------------------------------------------
  // lanes and output enables (low = driving)
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LANE_ONE  = 2'b00,
    LANE_TWO  = 2'b01,
    LANE_FOUR = 2'b10
  } sfr_lane_t;

  localparam logic [3:0]  OE_N_NONE        = 4'hF;
  localparam logic [3:0]  OE_N_ONE         = 4'hD;  // serial output sits on lane 1
  localparam logic [3:0]  OE_N_TWO         = 4'hC;
  localparam logic [3:0]  OE_N_FOUR        = 4'h0;

  typedef enum logic [2:0] {
    S_OPC   = 3'b000,
    S_ADDR  = 3'b001,
    S_DUMMY = 3'b010,
    S_DATA  = 3'b011,
    S_IGN   = 3'b100
  } sfr_state_t;

endpackage : sfr_pkg

// ===== src/sfr_pin_sampler.sv
module sfr_pin_sampler
  import sfr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       pause_n,
  input  wire logic [3:0] io_in,
  input  wire logic       quad_lane_enable,
  input  wire logic       dtr_mode,
  output logic            sclk_rise,
  output logic            sclk_fall,
  output logic            selected,
  output logic            paused,
  output logic [3:0]      io_smp
);

  typedef struct packed {
    logic       sclk_d;
    logic       rise;
    logic       fall;
    logic       sel;
    logic       hold;
    logic [3:0] io;
  } sfr_smp_t;

  sfr_smp_t st_reg;
  sfr_smp_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.sclk_d = sclk;
    st_next.rise = sclk & ~st_reg.sclk_d;
    st_next.fall = ~sclk & st_reg.sclk_d;
    st_next.sel  = ~chip_select_n;
    st_next.io   = io_in;
    if (chip_select_n || quad_lane_enable || dtr_mode) begin
      st_next.hold = 1'b0;
    end else if (!sclk) begin
      st_next.hold = ~pause_n;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign sclk_rise = st_reg.rise;
  assign sclk_fall = st_reg.fall;
  assign selected  = st_reg.sel;
  assign paused    = st_reg.hold;
  assign io_smp    = st_reg.io;

  a_pause_disabled: assert property (@(posedge clk) disable iff (reset)
    (clk_en && (quad_lane_enable || dtr_mode)) |=> !st_reg.hold)
    else $error("pause active while it is disabled");

  a_pause_clk_low: assert property (@(posedge clk) disable iff (reset)
    (st_reg.sel && $changed(st_reg.hold)) |-> $past(!sclk))
    else $error("pause changed while the serial clock was high");

endmodule : sfr_pin_sampler

// ===== src/sfr_read_front_end.sv
module sfr_read_front_end
  import sfr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic              sclk,
  input  wire logic              chip_select_n,
  input  wire logic              pause_n,
  input  wire logic [3:0]        io_in,
  output logic      [3:0]        io_out,
  output logic      [3:0]        io_oe_n,
  input  wire logic              write_in_progress,
  input  wire logic              quad_lane_enable,
  input  wire logic              four_lane_cmd_mode,
  input  wire logic              dtr_mode,
  input  wire logic [3:0]        dual_dummy_cycles,
  input  wire logic [3:0]        quad_dummy_cycles,
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic [7:0]        mem_data,
  output logic                   opcode_skip_read,
  output logic                   cmd_active
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    sfr_state_t        state;
    sfr_lane_t         lane;
    logic [3:0]        dummy_tgt;
    logic              has_mode;
    logic [4:0]        cnt;
    logic [23:0]       sh;
    logic [7:0]        mode;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic              drv;
    logic              skip;
    logic              active;
    logic [3:0]        io_out;
    logic [3:0]        io_oe_n;
  } sfr_fe_t;

  sfr_fe_t    st_reg;
  sfr_fe_t    st_next;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       selected;
  logic       paused;
  logic [3:0] io_smp;

  sfr_pin_sampler u_pins (
    .clk              (clk),
    .reset            (reset),
    .clk_en           (clk_en),
    .sclk             (sclk),
    .chip_select_n    (chip_select_n),
    .pause_n          (pause_n),
    .io_in            (io_in),
    .quad_lane_enable (quad_lane_enable),
    .dtr_mode         (dtr_mode),
    .sclk_rise        (sclk_rise),
    .sclk_fall        (sclk_fall),
    .selected         (selected),
    .paused           (paused),
    .io_smp           (io_smp)
  );

  // ------------------------------------------------------------
  // lane helpers
  // ------------------------------------------------------------
  logic [23:0] sh_in;
  logic [4:0]  cnt_inc;
  logic [4:0]  opc_last;
  logic [4:0]  addr_last;
  logic [2:0]  step;
  logic [3:0]  oe_mask;
  logic [7:0]  opc;
  logic [7:0]  mode_in;
  logic [7:0]  byte_out;

  always_comb begin
    cnt_inc = st_reg.cnt + 5'h01;
    mode_in = {st_reg.mode[5:0], io_smp[1:0]};
    case (st_reg.lane)
      LANE_TWO: begin
        sh_in     = {st_reg.sh[21:0], io_smp[1:0]};        // IO1 carries the MSB
        opc_last  = OPC_CLKS_SINGLE;
        addr_last = ADDR_CLKS_DUAL;
        step      = 3'h2;
        oe_mask   = OE_N_TWO;
      end
      LANE_FOUR: begin
        sh_in     = {st_reg.sh[19:0], io_smp[3:0]};
        opc_last  = OPC_CLKS_QUAD;
        addr_last = ADDR_CLKS_QUAD;
        step      = 3'h4;
        oe_mask   = OE_N_FOUR;
      end
      default: begin
        sh_in     = {st_reg.sh[22:0], io_smp[0]};          // MSB first
        opc_last  = OPC_CLKS_SINGLE;
        addr_last = ADDR_CLKS_SINGLE;
        step      = 3'h1;
        oe_mask   = OE_N_ONE;
      end
    endcase
    opc = sh_in[7:0];
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    byte_out = st_reg.data;
    if (!selected) begin
      // decoder restarts on every deselect
      st_next.active  = 1'b0;
      st_next.drv     = 1'b0;
      st_next.cnt     = 5'h00;
      st_next.io_oe_n = OE_N_NONE;
      if (st_reg.skip) begin
        st_next.state     = write_in_progress ? S_IGN : S_ADDR;
        st_next.lane      = LANE_TWO;
        st_next.dummy_tgt = dual_dummy_cycles;
        st_next.has_mode  = 1'b1;
      end else begin
        st_next.state = S_OPC;
        st_next.lane  = four_lane_cmd_mode ? LANE_FOUR : LANE_ONE;
      end
    end else if (paused) begin
      // state is frozen, edges and input are dropped
      st_next.io_oe_n = OE_N_NONE;
      st_next.active  = 1'b0;
    end else begin
      st_next.active = 1'b1;
      if (st_reg.state == S_DATA && st_reg.drv) begin
        st_next.io_oe_n = oe_mask;
      end
      if (sclk_rise) begin
        case (st_reg.state)
          S_OPC: begin
            st_next.sh  = sh_in;
            st_next.cnt = cnt_inc;
            if (cnt_inc == opc_last) begin
              st_next.cnt      = 5'h00;
              st_next.has_mode = 1'b0;
              st_next.state    = S_ADDR;
              if (st_reg.lane == LANE_FOUR) begin
                st_next.dummy_tgt = quad_dummy_cycles;
                if (opc != OPC_FAST_READ && opc != OPC_FOUR_LANE_IO &&
                    opc != OPC_UNIQUE_ID && opc != OPC_PARAM_TABLE &&
                    opc != OPC_INFO_ROW) begin
                  st_next.state = S_IGN;
                end
              end else begin
                case (opc)
                  OPC_NORMAL_READ: st_next.dummy_tgt = DUMMY_NONE;
                  OPC_FAST_READ:   st_next.dummy_tgt = DUMMY_FAST;
                  OPC_TWO_LANE_IO: begin
                    st_next.lane      = LANE_TWO;
                    st_next.dummy_tgt = dual_dummy_cycles;
                    st_next.has_mode  = 1'b1;
                  end
                  default:         st_next.state = S_IGN;
                endcase
              end
              if (write_in_progress) begin
                st_next.state = S_IGN;
              end
            end
          end
          S_ADDR: begin
            st_next.sh  = sh_in;
            st_next.cnt = cnt_inc;
            if (cnt_inc == addr_last) begin
              st_next.addr  = sh_in[ADDR_W-1:0];            // bit 23 dropped
              st_next.cnt   = 5'h00;
              st_next.mode  = 8'h00;
              st_next.state = (st_reg.dummy_tgt == DUMMY_NONE) ? S_DATA : S_DUMMY;
            end
          end
          S_DUMMY: begin
            st_next.cnt = cnt_inc;
            if (st_reg.has_mode && st_reg.cnt < MODE_CLKS_DUAL) begin
              st_next.mode = mode_in;
              if (cnt_inc == MODE_CLKS_DUAL) begin
                st_next.skip = (mode_in[7:4] == SKIP_KEY);
              end
            end
            if (cnt_inc == {1'b0, st_reg.dummy_tgt}) begin
              st_next.cnt   = 5'h00;
              st_next.state = S_DATA;
            end
          end
          default: begin
            // data phase and ignored commands leave the input unread
          end
        endcase
      end
      if (sclk_fall && st_reg.state == S_DATA) begin
        if (st_reg.cnt[2:0] == 3'h0) begin
          byte_out     = mem_data;
          st_next.addr = st_reg.addr + 1'b1;                // wraps to zero
        end
        case (st_reg.lane)
          LANE_TWO:  st_next.io_out = {2'b00, byte_out[7:6]};
          LANE_FOUR: st_next.io_out = byte_out[7:4];
          default:   st_next.io_out = {2'b00, byte_out[7], 1'b0};
        endcase
        st_next.data    = byte_out << step;
        st_next.cnt     = {2'b00, st_reg.cnt[2:0] + step};
        st_next.drv     = 1'b1;
        st_next.io_oe_n = oe_mask;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg         <= '0;
      st_reg.io_oe_n <= OE_N_NONE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign io_out           = st_reg.io_out;
  assign io_oe_n          = st_reg.io_oe_n;
  assign mem_addr         = st_reg.addr;
  assign opcode_skip_read = st_reg.skip;
  assign cmd_active       = st_reg.active;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_idle_lanes_float: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !selected) |=> (st_reg.io_oe_n == OE_N_NONE && !st_reg.active))
    else $error("lanes driven or decoder busy while deselected");

  a_paused_lanes_float: assert property (@(posedge clk) disable iff (reset)
    (clk_en && selected && paused) |=> (st_reg.io_oe_n == OE_N_NONE && !st_reg.active))
    else $error("lanes driven while paused");

  a_busy_ignores_cmd: assert property (@(posedge clk) disable iff (reset)
    (clk_en && selected && !paused && sclk_rise && st_reg.state == S_OPC &&
     cnt_inc == opc_last && write_in_progress) |=> st_reg.state == S_IGN)
    else $error("read accepted while a write is in progress");

  a_ignored_quiet: assert property (@(posedge clk) disable iff (reset)
    st_reg.state == S_IGN |-> st_reg.io_oe_n == OE_N_NONE)
    else $error("ignored command drives the lanes");

  a_normal_no_dummy: assert property (@(posedge clk) disable iff (reset)
    (clk_en && selected && !paused && sclk_rise && st_reg.state == S_ADDR &&
     st_reg.dummy_tgt == DUMMY_NONE && cnt_inc == addr_last) |=> st_reg.state == S_DATA)
    else $error("normal read did not enter data right after the address");

  a_addr_step: assert property (@(posedge clk) disable iff (reset)
    (clk_en && selected && !paused && sclk_fall && st_reg.state == S_DATA &&
     st_reg.cnt[2:0] == 3'h0) |=> st_reg.addr == $past(st_reg.addr) + 1'b1)
    else $error("read address did not advance by one with wrap");

  a_data_on_fall: assert property (@(posedge clk) disable iff (reset)
    (st_reg.state == S_DATA && $changed(st_reg.io_out)) |-> $past(sclk_fall))
    else $error("data lane changed away from a falling clock edge");

  sequence mode_last_clock;
    clk_en && selected && !paused && sclk_rise && st_reg.state == S_DUMMY &&
      st_reg.has_mode && cnt_inc == MODE_CLKS_DUAL;
  endsequence

  sequence skip_follows_key;
    ##1 (st_reg.skip == ($past(st_reg.mode[5:2]) == SKIP_KEY));
  endsequence

  a_skip_from_mode: assert property (@(posedge clk) disable iff (reset)
    mode_last_clock |-> skip_follows_key)
    else $error("opcode skipping does not follow the mode bits");

endmodule : sfr_read_front_end

// ===== verif/sfr_host_model.sv
module sfr_host_model
  import sfr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n,
  output logic            sclk,
  output logic            chip_select_n,
  output logic            pause_n,
  output logic [3:0]      io_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] drv_en;
  logic [3:0] drv_val;
  logic       float_pat;

  initial begin
    sclk          = 1'b0;
    chip_select_n = 1'b1;
    pause_n       = 1'b1;
    drv_en        = 4'h0;
    drv_val       = 4'h0;
    float_pat     = 1'b0;
  end

  // floating lanes toggle so a stale level can never pass for data
  always @(negedge clk) float_pat <= ~float_pat;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = !io_oe_n[i] ? io_out[i] : drv_en[i] ? drv_val[i] : float_pat ^ i[0];
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // clock rests low outside frames
  task automatic select(input logic on);
    sclk   = 1'b0;
    drv_en = 4'h0;
    wait_clk(4);
    chip_select_n = ~on;
    wait_clk(4);
  endtask : select

  // low half carries new lane values, sample late in the high half
  task automatic cyc(input logic [3:0] en, input logic [3:0] val,
                     output logic [3:0] dout, output logic [3:0] oe_n);
    sclk    = 1'b0;
    drv_en  = en;
    drv_val = val;
    wait_clk(4);
    sclk = 1'b1;
    wait_clk(4);
    dout = io_in;
    oe_n = io_oe_n;
  endtask : cyc

  task automatic hold(input logic run);
    sclk = 1'b0;
    wait_clk(2);
    pause_n = run;
    wait_clk(4);
  endtask : hold
endmodule : sfr_host_model

// ===== verif/serial_flash_read_front_end_tb_top.sv
module serial_flash_read_front_end_tb_top
  import sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk;
  logic              clk_en;
  logic              reset;
  logic              write_in_progress;
  logic              quad_lane_enable;
  logic              four_lane_cmd_mode;
  logic              dtr_mode;
  logic [3:0]        dual_dummy_cycles;
  logic [3:0]        quad_dummy_cycles;
  logic              sclk;
  logic              chip_select_n;
  logic              pause_n;
  logic [3:0]        io_in;
  logic [3:0]        io_out;
  logic [3:0]        io_oe_n;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0]        mem_data;
  logic              opcode_skip_read;
  logic              cmd_active;
  int                bad_count;
  int                n_tests;

  // -------------------------------------------------------------
  // clock, memory image, instances
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // high address bits mixed in so a missed wrap shows
  function automatic logic [7:0] byte_at(input logic [ADDR_W-1:0] a);
    return a[7:0] + {1'b0, a[22:16]};
  endfunction : byte_at

  assign mem_data = byte_at(mem_addr);

  sfr_host_model host (.clk(clk), .io_out(io_out), .io_oe_n(io_oe_n), .sclk(sclk),
                       .chip_select_n(chip_select_n), .pause_n(pause_n), .io_in(io_in));

  sfr_read_front_end DUT (.clk(clk), .reset(reset), .clk_en(clk_en), .sclk(sclk),
    .chip_select_n(chip_select_n), .pause_n(pause_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .write_in_progress(write_in_progress),
    .quad_lane_enable(quad_lane_enable), .four_lane_cmd_mode(four_lane_cmd_mode),
    .dtr_mode(dtr_mode), .dual_dummy_cycles(dual_dummy_cycles),
    .quad_dummy_cycles(quad_dummy_cycles), .mem_addr(mem_addr), .mem_data(mem_data),
    .opcode_skip_read(opcode_skip_read), .cmd_active(cmd_active));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic send(input logic [31:0] v, input int nbits, input int lanes);
    logic [31:0] s;
    logic [3:0]  d;
    logic [3:0]  o;
    s = v << (32 - nbits);
    for (int k = 0; k < nbits; k += lanes) begin
      host.cyc((lanes == 4) ? 4'hF : (lanes == 2) ? 4'h3 : 4'h1, s[31:28] >> (4 - lanes), d, o);
      s = s << lanes;
      check("oe during input", OE_N_NONE, o);
    end
  endtask : send

  // host floats every lane, the wire toggles meanwhile
  task automatic idle(input int n);
    logic [3:0] d;
    logic [3:0] o;
    repeat (n) begin
      host.cyc(4'h0, 4'h0, d, o);
      check("oe while floating", OE_N_NONE, o);
    end
  endtask : idle

  // single lane keeps toggling the serial input, which must be ignored
  task automatic get(input int lanes, input int ncyc, output logic [7:0] b, output logic [3:0] oe);
    logic [3:0] d;
    b = 8'h00;
    for (int k = 0; k < ncyc; k++) begin
      host.cyc({3'h0, lanes == 1}, k[0] ? 4'hF : 4'h0, d, oe);
      b = (lanes == 4) ? {b[3:0], d} : (lanes == 2) ? {b[5:0], d[1:0]} : {b[6:0], d[1]};
    end
  endtask : get

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_normal(input logic [23:0] a0);
    logic [7:0]        b;
    logic [3:0]        oe;
    logic [ADDR_W-1:0] a;
    a = a0[ADDR_W-1:0];
    host.select(1'b1);
    send(32'(OPC_NORMAL_READ), 8, 1);
    send(32'(a0), 24, 1);
    for (int i = 0; i < 3; i++) begin
      get(1, 8, b, oe);
      check("normal byte", 32'(byte_at(a)), 32'(b));
      check("normal oe", 32'(OE_N_ONE), 32'(oe));
      a = a + 1'b1;
    end
    host.select(1'b0);
    check("oe after deselect", 32'(OE_N_NONE), 32'(io_oe_n));
  endtask : t_normal

  task automatic t_fast;
    logic [7:0] b;
    logic [3:0] oe;
    host.select(1'b1);
    send(32'(OPC_FAST_READ), 8, 1);
    send(32'h000100, 24, 1);
    send(32'h0, 8, 1);
    for (int i = 0; i < 2; i++) begin
      get(1, 8, b, oe);
      check("fast byte", 32'(byte_at(23'h100 + 23'(i))), 32'(b));
    end
    get(1, 4, b, oe);
    check("fast partial oe", 32'(OE_N_ONE), 32'(oe));
    // deselect while frozen: nothing may move until the enable returns
    clk_en = 1'b0;
    host.select(1'b0);
    check("frozen oe", 32'(OE_N_ONE), 32'(io_oe_n));
    clk_en = 1'b1;
    host.wait_clk(3);
    check("fast stop oe", 32'(OE_N_NONE), 32'(io_oe_n));
  endtask : t_fast

  task automatic t_busy;
    logic [7:0] b;
    logic [3:0] oe;
    write_in_progress = 1'b1;
    host.select(1'b1);
    send(32'(OPC_NORMAL_READ), 8, 1);
    send(32'h000040, 24, 1);
    get(1, 8, b, oe);
    check("busy oe", 32'(OE_N_NONE), 32'(oe));
    host.select(1'b0);
    write_in_progress = 1'b0;
  endtask : t_busy

  task automatic t_quad;
    logic [7:0]        b;
    logic [3:0]        oe;
    logic [ADDR_W-1:0] a;
    logic [7:0]        ops [6];
    ops = '{OPC_FAST_READ, OPC_FOUR_LANE_IO, OPC_UNIQUE_ID, OPC_PARAM_TABLE, OPC_INFO_ROW,
            OPC_NORMAL_READ};
    four_lane_cmd_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = 23'h012340 + 23'(i);
      quad_dummy_cycles = (i == 1) ? 4'h8 : DUMMY_QUAD_DEF;
      host.select(1'b1);
      send(32'(ops[i]), 8, 4);
      send(32'(a), 24, 4);
      idle(int'(quad_dummy_cycles));
      get(4, 2, b, oe);
      check("quad oe", 32'((i < 5) ? OE_N_FOUR : OE_N_NONE), 32'(oe));
      if (i < 5) begin
        check("quad byte", 32'(byte_at(a)), 32'(b));
      end
      host.select(1'b0);
    end
    four_lane_cmd_mode = 1'b0;
    quad_dummy_cycles  = DUMMY_QUAD_DEF;
  endtask : t_quad

  task automatic t_dual;
    logic [7:0]        b;
    logic [3:0]        oe;
    logic [ADDR_W-1:0] a;
    for (int p = 0; p < 2; p++) begin
      a = 23'h0345F0 + 23'(p * 32);
      // skip mode latches the dummy count while deselected
      dual_dummy_cycles = (p == 0) ? DUMMY_DUAL_DEF : 4'h6;
      host.select(1'b1);
      if (p == 0) begin
        send(32'(OPC_TWO_LANE_IO), 8, 1);
      end
      send(32'(a), 24, 2);
      send((p == 0) ? 32'hA : 32'h5, 4, 2);
      idle(int'(dual_dummy_cycles) - 2);
      for (int i = 0; i < 2; i++) begin
        get(2, 4, b, oe);
        check("dual byte", 32'(byte_at(a + 23'(i))), 32'(b));
        check("dual oe", 32'(OE_N_TWO), 32'(oe));
      end
      host.select(1'b0);
      check("skip mode", (p == 0) ? 32'h1 : 32'h0, 32'(opcode_skip_read));
    end
    dual_dummy_cycles = DUMMY_DUAL_DEF;
    t_normal(24'h000010);
  endtask : t_dual

  task automatic t_pause;
    logic [7:0] b;
    logic [7:0] hi;
    logic [3:0] oe;
    for (int j = 0; j < 3; j++) begin
      quad_lane_enable = (j == 1);
      dtr_mode         = (j == 2);
      host.select(1'b1);
      send(32'(OPC_NORMAL_READ), 8, 1);
      send(32'h000200, 24, 1);
      get(1, 4, hi, oe);
      host.hold(1'b0);
      check("paused oe", 32'((j == 0) ? OE_N_NONE : OE_N_ONE), 32'(io_oe_n));
      check("paused active", (j == 0) ? 32'h0 : 32'h1, 32'(cmd_active));
      if (j == 0) begin
        idle(3);
      end
      host.hold(1'b1);
      get(1, 4, b, oe);
      check("resumed byte", 32'(byte_at(23'h200)), 32'({hi[3:0], b[3:0]}));
      host.select(1'b0);
    end
    quad_lane_enable = 1'b0;
    dtr_mode         = 1'b0;
  endtask : t_pause

  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    #500000;
    bad_count++;
    finish_test();
  end

  initial begin
    bad_count          = 0;
    n_tests            = 0;
    reset              = 1'b1;
    clk_en             = 1'b1;
    write_in_progress  = 1'b0;
    quad_lane_enable   = 1'b0;
    four_lane_cmd_mode = 1'b0;
    dtr_mode           = 1'b0;
    dual_dummy_cycles  = DUMMY_DUAL_DEF;
    quad_dummy_cycles  = DUMMY_QUAD_DEF;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check("reset oe", 32'(OE_N_NONE), 32'(io_oe_n));
    check("reset skip", 32'h0, 32'({mem_addr, opcode_skip_read, cmd_active}));
    t_normal(24'hFFFFFE);
    t_fast();
    t_busy();
    t_quad();
    t_dual();
    t_pause();
    finish_test();
  end
endmodule : serial_flash_read_front_end_tb_top
